// *** shared/scs_pkg.sv ***
package scs_pkg;
   // -----------------------------
   // register map (byte addresses)
   // -----------------------------
   localparam logic [11:0] ADDR_FUSE = 12'h000;
   localparam logic [11:0] ADDR_FAST_TRIM = 12'h004;
   localparam logic [11:0] ADDR_LP_TRIM = 12'h008;
   localparam logic [11:0] ADDR_TEMP_A = 12'h00c;
   localparam logic [11:0] ADDR_TEMP_B = 12'h010;
   localparam logic [11:0] ADDR_STATUS = 12'h014;
   localparam logic [11:0] ADDR_WAKE = 12'h018;
   // -----------------------------
   // field positions in fuse word
   // -----------------------------
   localparam int FUSE_SRC_LSB = 0;
   localparam int FUSE_SUT_BIT = 4;
   localparam int FUSE_LPF_LSB = 5;
   localparam int FUSE_DIV8_BIT = 8;
   // -----------------------------
   // clock source codes
   // -----------------------------
   localparam logic [3:0] SRC_EXT = 4'h0;
   localparam logic [3:0] SRC_FAST = 4'h2;
   localparam logic [3:0] SRC_LP = 4'h4;
   localparam logic [3:0] SRC_LFXT = 4'h6;
   // shipped fuse values: fast osc, sut 0 (programmed), lp 32 khz, div8 programmed
   localparam logic [3:0] SHIP_SRC = 4'h2;
   localparam logic SHIP_SUT = 1'b0;
   localparam logic [2:0] SHIP_LPF = 3'h7;
   localparam logic SHIP_DIV8 = 1'b0;
   localparam logic [2:0] SHIP_PRESCALE_LOG2 = 3'h3;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   // -----------------------------
   // timing
   // -----------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int RESET_DELAY_MS = 16;
   localparam int RESET_DELAY_CYC = CLK_HZ / 1000 * RESET_DELAY_MS;
   localparam int LP_HZ = 32_000;
   localparam int RESET_DELAY_LP = LP_HZ / 1000 * RESET_DELAY_MS;
   localparam int RESET_EXTRA_CK = 14;
   localparam int WAKE_SHORT_CK = 6;
   localparam int WAKE_258_CK = 258;
   localparam int WAKE_1K_CK = 1024;
   localparam int WAKE_16K_CK = 16384;
   localparam int WAKE_32K_CK = 32768;
   // output routing of oscillator enables
   typedef enum logic [2:0] {
      SCS_OSC_NONE = 3'h0,
      SCS_OSC_EXT = 3'h1,
      SCS_OSC_FAST = 3'h2,
      SCS_OSC_LP = 3'h3,
      SCS_OSC_LFXT = 3'h4,
      SCS_OSC_XTAL = 3'h5
   } scs_osc_e;
endpackage

// *** hdl/scs_delay.sv ***
`timescale 1ns/1ns
`default_nettype none
module scs_delay #(
   parameter int CW = 16
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic START,
   input wire logic TICK,
   input wire logic [CW-1:0] COUNT,
   output logic DONE
);
   logic [CW-1:0] cnt_q;
   logic run_q;
   logic done_q;
   wire last = (cnt_q <= CW'(1));
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else if (START) begin
         cnt_q <= COUNT;
         run_q <= 1'b1;
         done_q <= 1'b0;
      end else if (run_q && TICK) begin
         cnt_q <= cnt_q - CW'(1);
         run_q <= !last;
         done_q <= last;
      end else begin
         done_q <= 1'b0;
      end
   end
   assign DONE = done_q;
endmodule
`default_nettype wire

// *** hdl/scs_top.sv ***
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Function
// - decode codes 0000/0010/0100/0110 to sources
// - top bit set selects crystal, range bits; odd code with start-up fuse set selects none
// - fuse one unprogrammed, zero programmed
// - fuse bits readable, writes ignored
// - wake delay counted on selected clock
// - reset adds 32 kHz timed delay
// - reset loads fast oscillator factory trim
// - fast trim writable anytime, retunes oscillator
// - reset loads low-power oscillator factory trim
// - low-power frequency code select, reserved codes
// - watchdog timing from 32 kHz low-power
// - fast oscillator clocks watchdog only when it is the selected clock
// - two temperature trim registers
// - start-up time fuse picks delay
// - large steps only through prescaler
// - shipped default fast osc, div eight
module scs_top
   import scs_pkg::*;
#(
   parameter int RESET_DELAY = scs_pkg::RESET_DELAY_LP,
   parameter logic [7:0] FAST_FACTORY_TRIM = 8'h80,
   parameter logic [7:0] LP_FACTORY_TRIM = 8'h80
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic [3:0] CLK_SRC_SEL,
   input wire logic STARTUP_TIME_SEL,
   input wire logic [2:0] LOWPOWER_OSC_FREQ_BITS,
   input wire logic CLK_DIV_BY_EIGHT,
   input wire logic SEL_CLK_TICK,
   input wire logic LP32_TICK,
   input wire logic WAKE_REQ,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output scs_pkg::scs_osc_e OSC_EN,
   output logic [1:0] XTAL_RANGE,
   output logic [2:0] LP_FREQ_LOG2,
   output logic WDT_CLK_FAST,
   output logic [2:0] PRESCALE_LOG2,
   output logic [7:0] FAST_OSC_TRIM,
   output logic [7:0] LP_OSC_TRIM,
   output logic [7:0] FAST_TEMP_A,
   output logic [7:0] FAST_TEMP_B,
   output logic CPU_RUN
);
   import scs_pkg::*;
   initial begin
      if (RESET_DELAY < 1 || RESET_DELAY > 1_000_000_000) begin
         $error("scs_top: reset delay out of range");
      end
   end
   // -----------------------------
   // fuse sync and decode
   // -----------------------------
   logic [8:0] fz1_q;
   logic [8:0] fz2_q;
   logic [1:0] ws_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         fz1_q <= {SHIP_DIV8, SHIP_LPF, SHIP_SUT, SHIP_SRC};
         fz2_q <= {SHIP_DIV8, SHIP_LPF, SHIP_SUT, SHIP_SRC};
         ws_q <= 2'h0;
      end else begin
         fz1_q <= {CLK_DIV_BY_EIGHT, LOWPOWER_OSC_FREQ_BITS, STARTUP_TIME_SEL, CLK_SRC_SEL};
         fz2_q <= fz1_q;
         ws_q <= {ws_q[0], WAKE_REQ};
      end
   end
   // fuse word latched once the synchroniser holds pin levels
   logic [8:0] fuse_q;
   logic fuse_ld_q;
   logic [1:0] fuse_wait_q;
   wire fuse_ready = (fuse_wait_q == 2'h2);
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         fuse_q <= {SHIP_DIV8, SHIP_LPF, SHIP_SUT, SHIP_SRC};
         fuse_ld_q <= 1'b0;
         fuse_wait_q <= 2'h0;
      end else if (!fuse_ld_q) begin
         fuse_wait_q <= fuse_wait_q + 2'h1;
         if (fuse_ready) begin
            fuse_q <= fz2_q;
            fuse_ld_q <= 1'b1;
         end
      end
   end
   wire [3:0] src = fuse_q[FUSE_SRC_LSB +: 4];
   wire startup_time_sel = fuse_q[FUSE_SUT_BIT];
   wire [2:0] lpf = fuse_q[FUSE_LPF_LSB +: 3];
   wire div8_on = !fuse_q[FUSE_DIV8_BIT];
   function automatic scs_osc_e src_decode(input logic [3:0] s, input logic t, input logic [2:0] f);
      scs_osc_e r;
      r = SCS_OSC_NONE;
      if (s[3]) begin
         r = (s[0] && t) ? SCS_OSC_NONE : SCS_OSC_XTAL;
      end else if (s == SRC_EXT && !t) begin
         r = SCS_OSC_EXT;
      end else if (s == SRC_FAST && !t) begin
         r = SCS_OSC_FAST;
      end else if (s == SRC_LP && !t && f >= 3'h3) begin
         r = SCS_OSC_LP;
      end else if (s == SRC_LFXT) begin
         r = SCS_OSC_LFXT;
      end
      return r;
   endfunction
   scs_osc_e osc_sel;
   assign osc_sel = src_decode(src, startup_time_sel, lpf);
   wire src_valid = (osc_sel != SCS_OSC_NONE);
   assign XTAL_RANGE = src[3] ? src[2:1] : 2'h0;
   assign OSC_EN = fuse_ld_q ? osc_sel : SCS_OSC_NONE;
   // 111 = 32 khz ... 011 = 512 khz
   assign LP_FREQ_LOG2 = (osc_sel == SCS_OSC_LP) ? 3'(3'h7 - lpf) : 3'h0;
   // watchdog from fast osc only when it is the clock
   assign WDT_CLK_FAST = (osc_sel == SCS_OSC_FAST);
   assign PRESCALE_LOG2 = div8_on ? SHIP_PRESCALE_LOG2 : 3'h0;
   // -----------------------------
   // start-up sequencing
   // -----------------------------
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_RST = 2'b01,
      ST_RUN = 2'b11,
      ST_WAKE = 2'b10
   } scs_state_e;
   scs_state_e st_q;
   scs_state_e st_d;
   // wake length from the start-up fuse
   logic [15:0] wake_cnt;
   always_comb begin
      wake_cnt = 16'(WAKE_SHORT_CK);
      if (osc_sel == SCS_OSC_LFXT) begin
         wake_cnt = startup_time_sel ? 16'(WAKE_32K_CK) : 16'(WAKE_1K_CK);
      end else if (osc_sel == SCS_OSC_XTAL) begin
         if (src[0]) begin
            wake_cnt = 16'(WAKE_16K_CK);
         end else begin
            wake_cnt = startup_time_sel ? 16'(WAKE_1K_CK) : 16'(WAKE_258_CK);
         end
      end
   end
   logic wake_seen_q;
   wire wake_rise = ws_q[1] && !wake_seen_q;
   wire rst_start = (st_q == ST_LOAD) && fuse_ld_q && src_valid;
   wire wake_start = (st_q == ST_RUN) && wake_rise;
   wire rst_done;
   wire wake_done;
   // reset delay on the 32 khz tick
   scs_delay #(.CW(32)) u_rst_delay (
      .CLOCK(CLOCK),
      .ARST_N(ARST_N),
      .START(rst_start),
      .TICK(LP32_TICK),
      .COUNT(32'(RESET_DELAY + RESET_EXTRA_CK)),
      .DONE(rst_done)
   );
   // wake delay on the selected clock
   scs_delay #(.CW(16)) u_wake_delay (
      .CLOCK(CLOCK),
      .ARST_N(ARST_N),
      .START(wake_start),
      .TICK(SEL_CLK_TICK),
      .COUNT(wake_cnt),
      .DONE(wake_done)
   );
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_LOAD: st_d = rst_start ? ST_RST : ST_LOAD;
         ST_RST: st_d = rst_done ? ST_RUN : ST_RST;
         ST_RUN: st_d = wake_start ? ST_WAKE : ST_RUN;
         ST_WAKE: st_d = wake_done ? ST_RUN : ST_WAKE;
         default: st_d = ST_LOAD;
      endcase
   end
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q <= ST_LOAD;
         wake_seen_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wake_seen_q <= ws_q[1];
      end
   end
   assign CPU_RUN = (st_q == ST_RUN);
   // -----------------------------
   // ahb-lite slave
   // -----------------------------
   logic [11:0] a_q;
   logic wr_q;
   logic act_q;
   logic [7:0] ftrim_q;
   logic [7:0] ltrim_q;
   logic [7:0] ta_q;
   logic [7:0] tb_q;
   logic trim_ld_q;
   wire take = HSEL && HREADY && HTRANS[1];
   wire wr_ph = act_q && wr_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         a_q <= 12'h000;
         wr_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         a_q <= HADDR[11:0];
         wr_q <= HWRITE;
         act_q <= take;
      end
   end
   // factory trims loaded at reset exit, writable
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ftrim_q <= TRIM_RESET;
         ltrim_q <= TRIM_RESET;
         ta_q <= TRIM_RESET;
         tb_q <= TRIM_RESET;
         trim_ld_q <= 1'b0;
      end else if (!trim_ld_q) begin
         ftrim_q <= FAST_FACTORY_TRIM;
         ltrim_q <= LP_FACTORY_TRIM;
         trim_ld_q <= 1'b1;
      end else if (wr_ph) begin
         if (a_q == ADDR_FAST_TRIM) ftrim_q <= HWDATA[7:0];
         if (a_q == ADDR_LP_TRIM) ltrim_q <= HWDATA[7:0];
         if (a_q == ADDR_TEMP_A) ta_q <= HWDATA[7:0];
         if (a_q == ADDR_TEMP_B) tb_q <= HWDATA[7:0];
      end
   end
   // fuse word has no write path
   logic [31:0] rd_mux;
   always_comb begin
      case (a_q)
         ADDR_FUSE: rd_mux = {23'h0, fuse_q};
         ADDR_FAST_TRIM: rd_mux = {24'h0, ftrim_q};
         ADDR_LP_TRIM: rd_mux = {24'h0, ltrim_q};
         ADDR_TEMP_A: rd_mux = {24'h0, ta_q};
         ADDR_TEMP_B: rd_mux = {24'h0, tb_q};
         ADDR_STATUS: rd_mux = {26'h0, st_q, 1'b0, src_valid, osc_sel[2:1]};
         ADDR_WAKE: rd_mux = {16'h0, wake_cnt};
         default: rd_mux = 32'h0;
      endcase
   end
   logic [31:0] rdata_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= rd_mux;
      end
   end
   assign HRDATA = act_q && !wr_q ? rd_mux : rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign FAST_OSC_TRIM = ftrim_q;
   assign LP_OSC_TRIM = ltrim_q;
   assign FAST_TEMP_A = ta_q;
   assign FAST_TEMP_B = tb_q;
   // -----------------------------
   // checks
   // -----------------------------
   // no oscillator for a reserved code
   a_inval_none: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (src == 4'h1 || src == 4'h3) |-> OSC_EN == SCS_OSC_NONE)
      else $error("reserved code enabled an oscillator");
   a_xtal_range: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (osc_sel == SCS_OSC_XTAL) |-> XTAL_RANGE == src[2:1])
      else $error("crystal range wrong");
   a_fuse_fixed: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      fuse_ld_q && $past(fuse_ld_q) |-> $stable(fuse_q))
      else $error("fuse word changed");
   a_trim_write: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      trim_ld_q && wr_ph && a_q == ADDR_FAST_TRIM |=> FAST_OSC_TRIM == $past(HWDATA[7:0]))
      else $error("fast trim not written");
   a_trim_load: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      $rose(trim_ld_q) |-> FAST_OSC_TRIM == FAST_FACTORY_TRIM && LP_OSC_TRIM == LP_FACTORY_TRIM)
      else $error("factory trims not loaded");
   a_rst_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      rst_start |=> !CPU_RUN [*8])
      else $error("cpu ran during reset delay");
   a_wake_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      wake_start |=> !CPU_RUN [*6])
      else $error("cpu ran during wake delay");
   a_lp_freq: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      osc_sel == SCS_OSC_LP && lpf == 3'h7 |-> LP_FREQ_LOG2 == 3'h0)
      else $error("low-power frequency wrong");
   c_wake: cover property (@(posedge CLOCK) disable iff (!ARST_N) wake_done);
   c_run: cover property (@(posedge CLOCK) disable iff (!ARST_N) $rose(CPU_RUN));
   c_trim: cover property (@(posedge CLOCK) disable iff (!ARST_N) wr_ph);
endmodule
`default_nettype wire

// *** verification/scs_clk_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module scs_clk_src_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] per,
   output logic sel_tick,
   output logic lp_tick
);
   // ----------------------------
   // tick source at the pins
   // ----------------------------
   logic [7:0] per_q;
   logic [7:0] cnt_q;
   logic [3:0] lp_q;
   always_ff @(posedge clk) begin
      if (!arst_n) begin
         per_q <= per;
      end
   end
   // low-power tick every 16 clock cycles
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 8'h00;
         lp_q <= 4'h0;
      end else begin
         cnt_q <= (cnt_q >= per_q - 8'h01) ? 8'h00 : cnt_q + 8'h01;
         lp_q <= lp_q + 4'h1;
      end
   end
   assign sel_tick = arst_n && (cnt_q == 8'h00);
   assign lp_tick = arst_n && (lp_q == 6'h00);
endmodule
`default_nettype wire

// *** verification/system_clock_source_select_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
$display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module system_clock_source_select_bench;
   import scs_pkg::*;
   // ----------------------------
   // setup
   // ----------------------------
   localparam logic [7:0] FT = 8'h3c;
   localparam logic [7:0] LT = 8'hc5;
   localparam int RD = 20;
   // low-power tick period of the partner model, in clock cycles
   localparam int LPP = 16;
   localparam int RX = (RD + RESET_EXTRA_CK) * LPP;
   localparam int RW = RX + 3 * LPP;
   logic clk, arst_n, startup_time_sel, div8, wake, hsel, hwrite, sel_tick, lp_tick;
   logic hreadyout, hresp, wdt_fast, cpu_run;
   logic [3:0] src;
   logic [2:0] lpf, hsize, lpf_log2, pre;
   logic [1:0] htrans, xrange;
   logic [31:0] haddr, hwdata, hrdata, hr_q, rd;
   logic [7:0] per, ft, lt, ta, tb;
   scs_osc_e osc, eo;
   int num_errors, checks_done, n, m;
   scs_top #(.RESET_DELAY(RD), .FAST_FACTORY_TRIM(FT), .LP_FACTORY_TRIM(LT)) dut_u (
      .CLOCK(clk), .ARST_N(arst_n), .CLK_SRC_SEL(src), .STARTUP_TIME_SEL(startup_time_sel),
      .LOWPOWER_OSC_FREQ_BITS(lpf), .CLK_DIV_BY_EIGHT(div8), .SEL_CLK_TICK(sel_tick),
      .LP32_TICK(lp_tick), .WAKE_REQ(wake), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .OSC_EN(osc),
      .XTAL_RANGE(xrange), .LP_FREQ_LOG2(lpf_log2), .WDT_CLK_FAST(wdt_fast),
      .PRESCALE_LOG2(pre), .FAST_OSC_TRIM(ft), .LP_OSC_TRIM(lt), .FAST_TEMP_A(ta),
      .FAST_TEMP_B(tb), .CPU_RUN(cpu_run));
   scs_clk_src_model part_u (.clk(clk), .arst_n(arst_n), .per(per),
      .sel_tick(sel_tick), .lp_tick(lp_tick));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always_ff @(posedge clk) hr_q <= hrdata;
   // ----------------------------
   // tasks
   // ----------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic limit(input int k, input int b);
      if (k >= b) begin
         num_errors++;
         complete_run();
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      #1 rd = hr_q;
      limit(k, 50);
   endtask
   task automatic do_reset(input logic [3:0] s, input logic u, input logic [2:0] f,
                           input logic v, input logic [7:0] p);
      @(posedge clk);
      arst_n <= 1'b0;
      src <= s;
      startup_time_sel <= u;
      lpf <= f;
      div8 <= v;
      per <= p;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (cpu_run !== 1'b1 && n < RW);
   endtask
   task automatic wake_case(input logic [3:0] s, input logic u, input logic [7:0] p,
                            input int x);
      do_reset(s, u, 3'h7, 1'b1, p);
      @(posedge clk);
      wake <= 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (cpu_run !== 1'b0 && n < 20);
      limit(n, 20);
      m = 0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 40000) begin
         if (sel_tick === 1'b1) m++;
         @(negedge clk);
         n++;
      end
      limit(n, 40000);
      `CHK("wake ticks", 1'b1, (m >= x - 1 && m <= x + 2))
      @(posedge clk);
      wake <= 1'b0;
   endtask
   // ----------------------------
   // tests
   // ----------------------------
   initial begin
      {arst_n, wake, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      {src, startup_time_sel, lpf, div8, per} = {SHIP_SRC, SHIP_SUT, SHIP_LPF, SHIP_DIV8, 8'd2};
      num_errors = 0;
      checks_done = 0;
      do_reset(SHIP_SRC, SHIP_SUT, SHIP_LPF, SHIP_DIV8, 8'd2);
      `CHK("reset delay", 1'b1, (n >= RX && n <= RX + LPP))
      `CHK("osc", SCS_OSC_FAST, osc)
      `CHK("prescale", SHIP_PRESCALE_LOG2, pre)
      `CHK("wdt fast", 1'b1, wdt_fast)
      `CHK("fast trim", FT, ft)
      `CHK("lp trim", LT, lt)
      `CHK("temp a", TRIM_RESET, ta)
      `CHK("resp", 1'b0, hresp)
      bus(1'b0, ADDR_FUSE, 32'h0);
      `CHK("fuse", 32'h0e2, rd)
      bus(1'b1, ADDR_FUSE, 32'h1ff);
      bus(1'b0, ADDR_FUSE, 32'h0);
      `CHK("fuse kept", 32'h0e2, rd)
      bus(1'b0, ADDR_WAKE, 32'h0);
      `CHK("wake count", WAKE_SHORT_CK, rd)
      bus(1'b1, ADDR_FAST_TRIM, 32'h5a);
      `CHK("fast trim port", 8'h5a, ft)
      bus(1'b0, ADDR_FAST_TRIM, 32'h0);
      `CHK("fast trim read", 32'h5a, rd)
      bus(1'b1, ADDR_TEMP_A, 32'h11);
      bus(1'b1, ADDR_TEMP_B, 32'h22);
      `CHK("temp a port", 8'h11, ta)
      `CHK("temp b port", 8'h22, tb)
      bus(1'b0, ADDR_TEMP_B, 32'h0);
      `CHK("temp b read", 32'h22, rd)
      bus(1'b1, 12'h040, 32'hff);
      bus(1'b0, 12'h040, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      $display("test defaults done");
      for (int c = 0; c < 16; c++) begin
         do_reset(c[3:0], 1'b0, 3'h7, 1'b1, 8'd2);
         eo = c == 0 ? SCS_OSC_EXT : c == 2 ? SCS_OSC_FAST : c == 4 ? SCS_OSC_LP :
              c == 6 ? SCS_OSC_LFXT : c >= 8 ? SCS_OSC_XTAL : SCS_OSC_NONE;
         `CHK("osc", eo, osc)
         `CHK("run", (eo != SCS_OSC_NONE), cpu_run)
         if (eo != SCS_OSC_NONE) `CHK("wdt fast", (c == 2), wdt_fast)
         `CHK("prescale", 3'h0, pre)
         if (c >= 8) `CHK("range", c[2:1], xrange)
         bus(1'b0, ADDR_FUSE, 32'h0);
         `CHK("fuse", {23'h0, 1'b1, 3'h7, 1'b0, c[3:0]}, rd)
      end
      $display("test sources done");
      for (int f = 0; f < 8; f++) begin
         do_reset(SRC_LP, 1'b0, f[2:0], 1'b1, 8'd2);
         `CHK("lp osc", (f >= 3 ? SCS_OSC_LP : SCS_OSC_NONE), osc)
         if (f >= 3) `CHK("lp freq", 3'(7 - f), lpf_log2)
         if (f >= 3) `CHK("lp wdt", 1'b0, wdt_fast)
      end
      do_reset(SRC_EXT, 1'b1, 3'h7, 1'b1, 8'd2);
      `CHK("reserved sut", SCS_OSC_NONE, osc)
      $display("test low power done");
      wake_case(SRC_FAST, 1'b0, 8'd2, WAKE_SHORT_CK);
      wake_case(4'h8, 1'b0, 8'd5, WAKE_258_CK);
      wake_case(4'h8, 1'b1, 8'd2, WAKE_1K_CK);
      wake_case(4'h9, 1'b0, 8'd1, WAKE_16K_CK);
      wake_case(SRC_LFXT, 1'b0, 8'd3, WAKE_1K_CK);
      wake_case(SRC_LFXT, 1'b1, 8'd1, WAKE_32K_CK);
      $display("test wake done");
      complete_run();
   end
endmodule
`default_nettype wire
